/* File: cal_pkg.sv */
// Shared constants and types for the converter calibration controller.
package cal_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets on the APB slave
  // ----------------------------------------------------------------
  localparam logic [7:0] A_MODE = 8'h00;
  localparam logic [7:0] A_STAT = 8'h04;
  localparam logic [7:0] A_DATA = 8'h08;
  localparam logic [7:0] A_OFS0 = 8'h0c;
  localparam logic [7:0] A_GAIN0 = 8'h18;
  localparam logic [7:0] A_ISTAT = 8'h24;
  localparam logic [7:0] A_IMASK = 8'h28;

  // ----------------------------------------------------------------
  // Operation codes, interrupt bits and calibration lengths
  // ----------------------------------------------------------------
  localparam logic [2:0] OP_IDLE = 3'h0;
  localparam logic [2:0] OP_CONT = 3'h1;
  localparam logic [2:0] OP_SINGLE = 3'h2;
  localparam logic [2:0] OP_STBY = 3'h3;
  localparam logic [2:0] OP_IZS = 3'h4;
  localparam logic [2:0] OP_IFS = 3'h5;
  localparam logic [2:0] OP_SZS = 3'h6;
  localparam logic [2:0] OP_SFS = 3'h7;
  localparam int IRQ_CAL = 0;
  localparam int IRQ_CONV = 1;
  localparam logic [5:0] DUR_SHORT_CHP = 6'd22;
  localparam logic [5:0] DUR_SHORT_NOCHP = 6'd24;
  localparam logic [5:0] DUR_LONG_CHP = 6'd44;
  localparam logic [5:0] DUR_LONG_NOCHP = 6'd48;
  localparam logic [1:0] MAX_CH = 2'h2;
  localparam logic [23:0] OFS_RST = 24'h000000;
  localparam logic [23:0] GAIN_RST = 24'h800000;
  localparam logic [23:0] DATA_MAX = 24'hffffff;
  localparam int GAIN_SHIFT = 23;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_SHORT = 2'h1;
  localparam logic [1:0] SRC_FULL = 2'h2;
  localparam logic [2:0] PIN_IDLE = 3'h7;

  // Mode register layout, bit 7 down to bit 0.
  typedef struct packed {
    logic [1:0] ch;
    logic fir_bypass;
    logic step_avg;
    logic chopping_enable;
    logic [2:0] operation_select;
  } mode_t;

  // Sequencer phase.
  typedef enum logic [1:0] {SQ_IDLE, SQ_CONV, SQ_CAL} seq_t;

  // Whole state of the controller.
  typedef struct packed {
    mode_t mode;
    seq_t seq;
    logic [5:0] cnt;
    logic [2:0][23:0] ofs;
    logic [2:0][23:0] gain;
    logic [23:0] data;
    logic ready_n;
    logic settled_n;
    logic analog_pd;
    logic filt_rst;
    logic ser_rst;
    logic step_eff;
    logic firb_eff;
    logic [1:0] src;
    logic [1:0] istat;
    logic [1:0] imask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [2:0] pin1;
    logic [2:0] pin2;
    logic sb_d;
  } state_t;

endpackage

/* File: cal_ctrl.sv */
// Calibration sequencer, reset-event handling and APB registers of the converter.
//
// Overview of operation
// R1: Ready high during calibration, low when finished.
// R2: Operation field returns to idle after calibration.
// R3: Calibration forces step averaging, FIR bypass off.
// R4: Internal zero-scale: 22/24 periods, updates offset.
// R5: Internal full-scale: 44/48 periods, updates gain.
// R6: System zero-scale: 22/24 periods, updates offset.
// R7: System full-scale: 22/24 periods, updates gain.
// R8: Host orders full-scale and zero-scale calibrations.
// R9: Host picks range for internal full-scale.
// R10: Host watches ready pin or status bit.
// R11: Reset restores defaults, flags, filter, serial port.
// R12: Standby, sync and idle writes reset filter.
// R13: Mode writes, 32 ones, data reads set flags.
// R14: Conversion subtracts offset, then scales by gain.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/100ps

module cal_ctrl
  import cal_pkg::*;
(
  // Clock and power-on reset.
  input wire logic clk,
  input wire logic rst_b,
  // APB slave.
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Device pins.
  input wire logic reset_pin_b,
  input wire logic standby_b,
  input wire logic sync_b,
  output logic rdy_n,
  // Serial port and filter.
  input wire logic ones32_seen,
  input wire logic out_tick,
  input wire logic filt_valid,
  input wire logic filt_settled,
  input wire logic [23:0] filt_data,
  output logic filter_settled_n,
  output logic filter_reset,
  output logic serial_reset,
  output logic analog_pd,
  output logic step_avg_en,
  output logic fir_bypass,
  output logic chopping_enable,
  output logic [1:0] cal_src,
  // Interrupt.
  output logic irq
);

  // ----------------------------------------------------------------
  // State and helpers
  // ----------------------------------------------------------------
  state_t s; // Registered state.
  state_t n; // Next state.
  localparam state_t RST_S = '{mode: '0, seq: SQ_IDLE, cnt: '0,
    ofs: {3{OFS_RST}}, gain: {3{GAIN_RST}}, data: '0, ready_n: 1'b1,
    settled_n: 1'b1, analog_pd: 1'b1, filt_rst: 1'b1, ser_rst: 1'b1,
    step_eff: 1'b0, firb_eff: 1'b0, src: SRC_EXT, istat: '0, imask: '0,
    irq: 1'b0, pready: 1'b0, pslverr: 1'b0, prdata: '0, pin1: PIN_IDLE,
    pin2: PIN_IDLE, sb_d: 1'b1};

  logic [1:0] ch_i; // Selected channel, code 3 folds onto the last.
  logic [5:0] dur; // Calibration length in output periods.
  logic cal_fin; // Last output period of a calibration.
  logic done; // APB access completes at this edge.
  logic [7:0] ofs_off; // Address relative to the offset block.
  logic [7:0] gain_off; // Address relative to the gain block.
  logic is_ofs; // Address hits an offset register.
  logic is_gain; // Address hits a gain register.
  logic signed [24:0] diff; // Offset-corrected filter word.
  logic signed [49:0] prod; // Gain-scaled word before truncation.
  logic [23:0] corr; // Clamped corrected result.
  logic [1:0] iset; // Interrupt events of this cycle.
  logic quiet; // No bus write or data read, no pin or serial event.

  assign ch_i = (s.mode.ch > MAX_CH) ? MAX_CH : s.mode.ch;
  assign cal_fin = (s.seq == SQ_CAL) && out_tick && !s.filt_rst && (s.cnt + 6'd1 == dur);
  assign done = psel && penable && s.pready;
  assign ofs_off = paddr - A_OFS0;
  assign gain_off = paddr - A_GAIN0;
  assign is_ofs = (paddr >= A_OFS0) && (paddr < A_GAIN0) && (paddr[1:0] == 2'h0);
  assign is_gain = (paddr >= A_GAIN0) && (paddr < A_ISTAT) && (paddr[1:0] == 2'h0);
  assign quiet = !(done && (pwrite || paddr == A_DATA)) && (s.pin2 == PIN_IDLE) && !ones32_seen;

  // Length of the running calibration from operation and chopping.
  // R4 R5 R6 R7: calibration durations.
  always_comb begin
    if (s.mode.operation_select == OP_IFS) begin
      dur = s.mode.chopping_enable ? DUR_LONG_CHP : DUR_LONG_NOCHP;
    end else begin
      dur = s.mode.chopping_enable ? DUR_SHORT_CHP : DUR_SHORT_NOCHP;
    end
  end

  // R14: offset first, then gain scaling.
  always_comb begin
    diff = $signed({1'b0, filt_data}) - $signed({1'b0, s.ofs[ch_i]});
    prod = (diff * $signed({1'b0, s.gain[ch_i]})) >>> GAIN_SHIFT;
    if (prod < 0) begin
      corr = '0;
    end else if (prod > $signed({26'h0, DATA_MAX})) begin
      corr = DATA_MAX;
    end else begin
      corr = prod[23:0];
    end
  end

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  // Events are applied in rising priority: sequencer, bus, pins.
  always_comb begin
    n = s;
    iset = '0;
    n.filt_rst = 1'b0;
    n.ser_rst = 1'b0;
    n.pin1 = {reset_pin_b, standby_b, sync_b};
    n.pin2 = s.pin1;
    n.sb_d = s.pin2[1];
    n.pready = psel && penable && !s.pready;
    // Read data and error are prepared in the first access cycle.
    if (psel && penable && !s.pready) begin
      n.pslverr = 1'b0;
      n.prdata = '0;
      if (paddr == A_MODE) begin
        n.prdata = {24'h0, s.mode};
      end else if (paddr == A_STAT) begin
        n.prdata = {29'h0, s.seq == SQ_CAL, s.settled_n, s.ready_n};
      end else if (paddr == A_DATA) begin
        n.prdata = {8'h0, s.data};
      end else if (is_ofs) begin
        n.prdata = {8'h0, s.ofs[ofs_off[3:2]]};
      end else if (is_gain) begin
        n.prdata = {8'h0, s.gain[gain_off[3:2]]};
      end else if (paddr == A_ISTAT) begin
        n.prdata = {30'h0, s.istat};
      end else if (paddr == A_IMASK) begin
        n.prdata = {30'h0, s.imask};
      end else begin
        n.pslverr = 1'b1;
      end
    end
    // Filter settling clears the settled flag.
    if (filt_settled) begin
      n.settled_n = 1'b0;
    end
    // Conversions load the data register and signal ready.
    if (s.seq == SQ_CONV && filt_valid && !s.filt_rst) begin
      n.data = corr;
      n.ready_n = 1'b0;
      iset[IRQ_CONV] = 1'b1;
      if (s.mode.operation_select == OP_SINGLE) begin
        n.mode.operation_select = OP_IDLE;
        n.seq = SQ_IDLE;
      end
    end
    // A tick seen while the filter is being reset is stale and is not counted.
    if (s.seq == SQ_CAL && out_tick && !s.filt_rst) begin
      n.cnt = s.cnt + 6'd1;
    end
    if (cal_fin) begin
      // R4 R6: zero-scale results go to the offset register.
      if (!s.mode.operation_select[0]) begin
        n.ofs[ch_i] = filt_data;
      end else begin
        // R5 R7: full-scale results go to the gain register.
        n.gain[ch_i] = filt_data;
      end
      // R2: operation field back to idle.
      n.mode.operation_select = OP_IDLE;
      n.seq = SQ_IDLE;
      n.src = SRC_EXT;
      // R1: ready falls only when the routine is finished.
      n.ready_n = 1'b0;
      iset[IRQ_CAL] = 1'b1;
    end
    // Register writes take effect at the completing edge.
    if (done && pwrite && !s.pslverr) begin
      if (paddr == A_MODE) begin
        n.mode = pwdata[7:0];
        n.cnt = '0;
        // R12 R13: every mode write resets the filter and sets flags.
        n.filt_rst = 1'b1;
        n.ready_n = 1'b1;
        n.settled_n = 1'b1;
        n.analog_pd = (pwdata[2:0] == OP_STBY);
        n.src = SRC_EXT;
        if (pwdata[2]) begin
          // R1: a calibration start drives ready high.
          n.seq = SQ_CAL;
          if (pwdata[2:0] == OP_IZS) begin
            n.src = SRC_SHORT;
          end else if (pwdata[2:0] == OP_IFS) begin
            n.src = SRC_FULL;
          end
        end else if (pwdata[2:0] == OP_CONT || pwdata[2:0] == OP_SINGLE) begin
          n.seq = SQ_CONV;
        end else begin
          n.seq = SQ_IDLE;
        end
      end else if (is_ofs) begin
        n.ofs[ofs_off[3:2]] = pwdata[23:0];
      end else if (is_gain) begin
        n.gain[gain_off[3:2]] = pwdata[23:0];
      end else if (paddr == A_IMASK) begin
        n.imask = pwdata[1:0];
      end
    end
    // R13: a data register read sets only the ready flag.
    if (done && !pwrite && paddr == A_DATA) begin
      n.ready_n = 1'b1;
    end
    // R13: 32 ones reset the serial port and set both flags.
    if (ones32_seen) begin
      n.ser_rst = 1'b1;
      n.ready_n = 1'b1;
      n.settled_n = 1'b1;
    end
    // R12: sync pin holds the filter in reset, mode kept.
    if (!s.pin2[0]) begin
      n.filt_rst = 1'b1;
      n.ready_n = 1'b1;
      n.settled_n = 1'b1;
    end
    // R12: standby pin also powers the analog section down.
    if (!s.pin2[1]) begin
      n.filt_rst = 1'b1;
      n.analog_pd = 1'b1;
      n.ready_n = 1'b1;
      n.settled_n = 1'b1;
    end else if (!s.sb_d) begin
      n.analog_pd = (s.mode.operation_select == OP_STBY);
    end
    // Sticky interrupt status: a new event beats a write-one clear.
    if (done && pwrite && !s.pslverr && paddr == A_ISTAT) begin
      n.istat = (s.istat & ~pwdata[1:0]) | iset;
    end else begin
      n.istat = s.istat | iset;
    end
    // R11: reset pin restores defaults but leaves power state alone.
    if (!s.pin2[2]) begin
      n.mode = RST_S.mode;
      n.seq = RST_S.seq;
      n.cnt = RST_S.cnt;
      n.ofs = RST_S.ofs;
      n.gain = RST_S.gain;
      n.data = RST_S.data;
      n.istat = RST_S.istat;
      n.imask = RST_S.imask;
      n.src = RST_S.src;
      n.ready_n = 1'b1;
      n.settled_n = 1'b1;
      n.filt_rst = 1'b1;
      n.ser_rst = 1'b1;
    end
    // R3: the full filter chain is used for calibration.
    n.step_eff = n.mode.step_avg && (n.seq != SQ_CAL);
    n.firb_eff = n.mode.fir_bypass && (n.seq != SQ_CAL);
    n.irq = |(n.istat & n.imask);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // R11: power-on reset loads every default and powers down.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RST_S;
    end else begin
      s <= n;
    end
  end

  // Outputs come straight from the state register.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign rdy_n = s.ready_n;
  assign filter_settled_n = s.settled_n;
  assign filter_reset = s.filt_rst;
  assign serial_reset = s.ser_rst;
  assign analog_pd = s.analog_pd;
  assign step_avg_en = s.step_eff;
  assign fir_bypass = s.firb_eff;
  assign chopping_enable = s.mode.chopping_enable;
  assign cal_src = s.src;
  assign irq = s.irq;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence cal_end_s;
    cal_fin && quiet;
  endsequence

  cal_ready_high_a: assert property (s.seq == SQ_CAL |-> rdy_n) // R1
    else $error("ready low during calibration");
  op_to_idle_a: assert property (cal_end_s |=> // R2
    s.mode.operation_select == OP_IDLE && !rdy_n && s.seq == SQ_IDLE)
    else $error("operation not idle after calibration");
  full_filter_a: assert property (s.seq == SQ_CAL |-> !step_avg_en && !fir_bypass) // R3
    else $error("filter shortcut during calibration");
  izs_len_a: assert property (cal_end_s ##0 (s.mode.operation_select == OP_IZS) // R4
    |-> s.cnt == (s.mode.chopping_enable ? 6'd21 : 6'd23) ##1 s.ofs[ch_i] == $past(filt_data))
    else $error("internal zero-scale length or result wrong");
  ifs_len_a: assert property (cal_end_s ##0 (s.mode.operation_select == OP_IFS) // R5
    |-> s.cnt == (s.mode.chopping_enable ? 6'd43 : 6'd47) ##1 s.gain[ch_i] == $past(filt_data))
    else $error("internal full-scale length or result wrong");
  szs_len_a: assert property (cal_end_s ##0 (s.mode.operation_select == OP_SZS) // R6
    |-> s.cnt == (s.mode.chopping_enable ? 6'd21 : 6'd23) ##1 s.ofs[ch_i] == $past(filt_data))
    else $error("system zero-scale length or result wrong");
  sfs_len_a: assert property (cal_end_s ##0 (s.mode.operation_select == OP_SFS) // R7
    |-> s.cnt == (s.mode.chopping_enable ? 6'd21 : 6'd23) ##1 s.gain[ch_i] == $past(filt_data))
    else $error("system full-scale length or result wrong");
  reset_pin_a: assert property ($fell(reset_pin_b) ##2 1'b1 |=> // R11
    s.mode.operation_select == OP_IDLE && rdy_n && filter_settled_n && serial_reset)
    else $error("reset pin did not restore defaults");
  standby_pin_a: assert property (!standby_b [*3] |=> analog_pd && filter_reset && rdy_n) // R12
    else $error("standby pin did not power down");
  ones_reset_a: assert property (ones32_seen && reset_pin_b |=> serial_reset && rdy_n) // R13
    else $error("serial reset missing after 32 ones");
  offset_gain_a: assert property (s.seq == SQ_CONV && filt_valid && !s.filt_rst && quiet // R14
    && s.gain[ch_i] == GAIN_RST && filt_data >= s.ofs[ch_i]
    |=> s.data == $past(filt_data) - $past(s.ofs[ch_i]))
    else $error("offset correction wrong at unity gain");

endmodule

/* File: cal_filter_model.sv */
// Filter and output-rate model that feeds the calibration controller.
`timescale 1ns/100ps

module cal_filter_model
#(
  parameter int TICK_DIV = 8
)
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_b,
  // Filter control.
  input wire logic filter_reset,
  // Filter results.
  output logic out_tick,
  output logic filt_valid,
  output logic filt_settled,
  output logic [23:0] filt_data
);
  logic [3:0] div_r; // Position within one output period.
  logic [23:0] word_r; // Word shown during the next tick.
  logic [2:0] settle_r; // Ticks since the last filter reset.

  // -----------------------------------------------------------
  // Output-rate divider
  // -----------------------------------------------------------
  // A filter reset restarts the period, so ticks never come early.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_r <= 4'h0;
      out_tick <= 1'b0;
      word_r <= 24'h1a2b3c;
      settle_r <= 3'h0;
      filt_settled <= 1'b0;
    end else if (filter_reset) begin
      div_r <= 4'h0;
      out_tick <= 1'b0;
      settle_r <= 3'h0;
      filt_settled <= 1'b0;
    end else begin
      div_r <= (div_r == 4'(TICK_DIV - 1)) ? 4'h0 : div_r + 4'h1;
      out_tick <= (div_r == 4'(TICK_DIV - 1));
      filt_settled <= out_tick && (settle_r == 3'h3);
      if (out_tick) begin
        word_r <= word_r + 24'h010203;
      end
      if (out_tick && settle_r != 3'h7) begin
        settle_r <= settle_r + 3'h1;
      end
    end
  end

  // Each tick carries a new word.
  assign filt_valid = out_tick;
  // Between ticks the word is not held; its inverse shows a late sample.
  assign filt_data = out_tick ? word_r : ~word_r;
endmodule

/* File: cal_ctrl_bench.sv */
// Self-checking bench for the calibration and reset-event controller.
`timescale 1ns/100ps
`define chk(nm, ex, got) begin \
  checked++; \
  if ((got) !== (ex)) begin \
    fail_count++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); \
  end \
end

module cal_ctrl_bench
  import cal_pkg::*;
;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic reset_pin_b, standby_b, sync_b, ones32_seen, rdy_n;
  logic out_tick, filt_valid, filt_settled;
  logic [23:0] filt_data;
  logic filter_settled_n, filter_reset, serial_reset, analog_pd;
  logic step_avg_en, fir_bypass, chopping_enable, irq;
  logic [1:0] cal_src;
  int checked = 0;
  int fail_count = 0;

  cal_ctrl uut (.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .reset_pin_b, .standby_b, .sync_b, .rdy_n, .ones32_seen,
    .out_tick, .filt_valid, .filt_settled, .filt_data, .filter_settled_n,
    .filter_reset, .serial_reset, .analog_pd, .step_avg_en, .fir_bypass,
    .chopping_enable, .cal_src, .irq);
  cal_filter_model filt (.clk, .rst_b, .filter_reset, .out_tick, .filt_valid,
    .filt_settled, .filt_data);

  // Free-running 250 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // -----------------------------------------------------------
  // Closing report and bus tasks
  // -----------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // Counts output ticks until ready falls; keeps the last ticked word.
  task automatic wait_rdy(output int n, output logic [23:0] d);
    int k;
    n = 0;
    d = 24'h0;
    for (k = 0; k < 1000; k++) begin
      @(negedge clk);
      if (rdy_n === 1'b0) break;
      if (out_tick === 1'b1) begin
        n++;
        d = filt_data;
      end
    end
    if (k >= 1000) begin
      fail_count++;
      report_and_stop();
    end
  endtask

  // -----------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------
  initial begin
    logic [2:0] ops [4];
    logic [2:0] op;
    logic [1:0] ch;
    logic [1:0] src;
    logic chop, e;
    logic [5:0] dur;
    logic [7:0] a;
    logic [31:0] q;
    logic [23:0] d;
    int n;
    // internal full-scale on the operating range, the model's only one.
    // Full-scale internal first, then zero-scale, then system pair.
    ops = '{OP_IFS, OP_IZS, OP_SZS, OP_SFS};
    {rst_b, psel, penable, pwrite, paddr, pwdata} = '0;
    {reset_pin_b, standby_b, sync_b, ones32_seen} = 4'b1110;
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(negedge clk);
    `chk("ready", 1'b1, rdy_n)
    `chk("settled", 1'b1, filter_settled_n)
    `chk("powerdown", 1'b1, analog_pd)
    rd(A_GAIN0, q);
    `chk("gain default", 32'h800000, q)
    apb(1'b0, 8'h30, 32'h0, q, e);
    `chk("unmapped err", 1'b1, e)
    `chk("unmapped data", 32'h0, q)
    wr(A_IMASK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      op = ops[i / 2];
      chop = (i % 2 == 0);
      ch = 2'(i % 3);
      if (op == OP_IFS) dur = chop ? DUR_LONG_CHP : DUR_LONG_NOCHP;
      else dur = chop ? DUR_SHORT_CHP : DUR_SHORT_NOCHP;
      wr(A_MODE, {24'h0, ch, 1'b1, 1'b1, chop, op});
      @(negedge clk);
      `chk("ready at start", 1'b1, rdy_n)
      `chk("step avg", 1'b0, step_avg_en)
      `chk("fir bypass", 1'b0, fir_bypass)
      `chk("chopping", chop, chopping_enable)
      src = (op == OP_IZS) ? SRC_SHORT : (op == OP_IFS) ? SRC_FULL : SRC_EXT;
      `chk("cal source", src, cal_src)
      wait_rdy(n, d);
      `chk("cal ticks", 32'(dur), n)
      `chk("source after", SRC_EXT, cal_src)
      rd(A_MODE, q);
      `chk("op after cal", 3'h0, q[2:0])
      rd(A_STAT, q);
      `chk("status ready", 1'b0, q[0])
      `chk("status idle", 1'b0, q[2])
      a = (op == OP_IZS || op == OP_SZS) ? A_OFS0 : A_GAIN0;
      rd(a + {4'h0, ch, 2'b00}, q);
      `chk("cal word", {8'h0, d}, q)
      `chk("irq cal", 1'b1, irq)
      wr(A_ISTAT, 32'h1);
      repeat (2) @(negedge clk);
      `chk("irq cleared", 1'b0, irq)
    end
    rd(A_DATA, q);
    @(negedge clk);
    `chk("read keeps settled", 1'b0, filter_settled_n)
    `chk("read sets ready", 1'b1, rdy_n)
    @(posedge clk);
    ones32_seen <= 1'b1;
    @(posedge clk);
    ones32_seen <= 1'b0;
    @(negedge clk);
    `chk("serial reset", 1'b1, serial_reset)
    `chk("ready ones", 1'b1, rdy_n)
    wr(A_OFS0, 32'h5);
    wr(A_GAIN0, 32'h400000);
    wr(A_MODE, {24'h0, 2'h0, 1'b0, 1'b0, 1'b1, OP_SINGLE});
    wait_rdy(n, d);
    rd(A_DATA, q);
    `chk("conv data", {8'h0, (d - 24'h5) >> 1}, q)
    wr(A_GAIN0, 32'h800000);
    wr(A_MODE, {24'h0, 2'h0, 1'b0, 1'b0, 1'b1, OP_SINGLE});
    wait_rdy(n, d);
    rd(A_DATA, q);
    `chk("conv unity", {8'h0, d - 24'h5}, q)
    @(negedge clk);
    `chk("ready data read", 1'b1, rdy_n)
    `chk("irq masked", 1'b0, irq)
    wr(A_IMASK, 32'h3);
    repeat (2) @(negedge clk);
    `chk("irq conv", 1'b1, irq)
    wr(A_ISTAT, 32'h3);
    @(posedge clk);
    standby_b <= 1'b0;
    repeat (5) @(negedge clk);
    `chk("standby pd", 1'b1, analog_pd)
    `chk("standby filt", 1'b1, filter_reset)
    `chk("standby ready", 1'b1, rdy_n)
    @(posedge clk);
    standby_b <= 1'b1;
    wr(A_MODE, {29'h0, OP_STBY});
    @(negedge clk);
    `chk("op3 pd", 1'b1, analog_pd)
    wr(A_MODE, {29'h0, OP_IDLE});
    @(negedge clk);
    `chk("op0 pd", 1'b0, analog_pd)
    `chk("op0 ready", 1'b1, rdy_n)
    @(posedge clk);
    sync_b <= 1'b0;
    repeat (5) @(negedge clk);
    `chk("sync filt", 1'b1, filter_reset)
    `chk("sync pd", 1'b0, analog_pd)
    @(posedge clk);
    sync_b <= 1'b1;
    wr(A_GAIN0 + 8'h4, 32'h123);
    @(posedge clk);
    reset_pin_b <= 1'b0;
    repeat (4) @(posedge clk);
    reset_pin_b <= 1'b1;
    repeat (5) @(negedge clk);
    `chk("pin pd kept", 1'b0, analog_pd)
    `chk("pin settled", 1'b1, filter_settled_n)
    rd(A_GAIN0 + 8'h4, q);
    `chk("pin gain", 32'h800000, q)
    report_and_stop();
  end
endmodule
